// ===== include/flash_pe_defines.svh
// Constants for the program and erase command sequencer.
// Assumes a 40 MHz core clock; cycle counts derive from it.
`ifndef FLASH_PE_DEFINES_SVH
`define FLASH_PE_DEFINES_SVH

`define OPC_QUAD_PROG    8'h32
`define OPC_SECT_ERASE   8'h20
`define OPC_BLK32_ERASE  8'h52
`define OPC_BLK64_ERASE  8'hD8
`define OPC_CHIP_ERASE_A 8'h60
`define OPC_CHIP_ERASE_B 8'hC7

`define OPC_LAST_BIT     5'h07
`define ADDR_LAST_BIT    5'h17
`define PAGE_BYTES       256
`define PAGE_BYTES_W     32'h00000100

`define SECT_MASK        24'hFFF000
`define BLK32_MASK       24'hFF8000
`define BLK64_MASK       24'hFF0000

`define CLK_MHZ          40
`define T_PP_US          1000
`define T_SE_MS          100
`define T_CE_MS          1000
`define PP_CYCLES        (`T_PP_US * `CLK_MHZ)
`define SE_CYCLES        (`T_SE_MS * 1000 * `CLK_MHZ)
`define CE_CYCLES        (`T_CE_MS * 1000 * `CLK_MHZ)

// Pin vector order: {io3..io0, sclk, cs_b}; chip select idles high
`define SYNC_RST         6'h01

`endif

// ===== include/flash_pe_pkg.sv
// Types for the program and erase command sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package flash_pe_pkg;

  typedef enum logic [2:0] {
    F_OPC,
    F_ADDR,
    F_DATA,
    F_END,
    F_SKIP
  } frame_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_PROG,
    OP_SE,
    OP_BE32,
    OP_BE64,
    OP_CE
  } op_t;

endpackage

// ===== hw/pin_sync.sv
// Two-flop synchronisers for the serial pins.
// Assumes pins are asynchronous to core_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "flash_pe_defines.svh"

module pin_sync (
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [5:0] pins_i,
  output var  logic [5:0] pins_o
);

  logic [5:0] meta_r;
  localparam logic [5:0] RST_VAL = `SYNC_RST;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_bit
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          meta_r[gi] <= RST_VAL[gi];
          pins_o[gi] <= RST_VAL[gi];
        end else begin
          meta_r[gi] <= pins_i[gi];
          pins_o[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ===== hw/spi_flash_program_erase.sv
// Program and erase command sequencer of a serial NOR flash.
// Assumes serial pins are asynchronous; protect decode and the
// write unlock latch live outside and share core_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "flash_pe_defines.svh"

module spi_flash_program_erase #(
  parameter int unsigned PP_CYCLES = `PP_CYCLES,
  parameter int unsigned SE_CYCLES = `SE_CYCLES,
  parameter int unsigned CE_CYCLES = `CE_CYCLES
) (
  input  wire logic               core_clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               spi_cs_b_i,
  input  wire logic               spi_sclk_i,
  input  wire logic [3:0]         spi_io_i,
  input  wire logic               quad_io_allow_bit_i,
  input  wire logic               write_unlock_latch_i,
  input  wire logic [4:0]         protect_bits_i,
  input  wire logic               protect_complement_i,
  input  wire logic               protect_hit_i,
  output var  logic               write_in_progress_o,
  output var  logic               write_unlock_clear_o,
  output var  logic [23:0]        target_addr_o,
  output var  flash_pe_pkg::op_t  target_kind_o,
  output var  logic               array_prog_o,
  output var  logic [23:0]        array_addr_o,
  output var  logic [7:0]         array_data_o,
  output var  logic               array_erase_o,
  output var  logic [23:0]        erase_base_o,
  output var  logic               cmd_discard_o
);

  logic [5:0]           pins_s;
  logic                 cs_d_r;
  logic                 sclk_d_r;
  flash_pe_pkg::frame_t state_r;
  flash_pe_pkg::frame_t state_nxt;
  flash_pe_pkg::op_t    cmd_r;
  logic [4:0]           bit_cnt_r;
  logic [6:0]           sh_r;
  logic [23:0]          addr_r;
  logic [3:0]           hi_r;
  logic                 nib_r;
  logic                 have_byte_r;
  logic                 cmd_seen_r;
  logic [7:0]           col_r;
  logic [7:0]           page_r [`PAGE_BYTES];
  logic                 mask_r [`PAGE_BYTES];
  logic                 busy_r;
  logic [31:0]          busy_cnt_r;

  pin_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .pins_i     ({spi_io_i, spi_sclk_i, spi_cs_b_i}),
    .pins_o     (pins_s)
  );

  wire       cs_s   = pins_s[0];
  wire       sclk_s = pins_s[1];
  wire [3:0] io_s   = pins_s[5:2];
  wire       si_s   = io_s[0];

  // Clock edges seen only while selected; select high aborts the frame
  wire sclk_rise_w = sclk_s & ~sclk_d_r & ~cs_s;
  wire cs_rise_w   = cs_s & ~cs_d_r;
  wire cs_fall_w   = ~cs_s & cs_d_r;

  wire [7:0]  opc_w       = {sh_r, si_s};
  wire [23:0] addr_nxt_w  = {addr_r[22:0], si_s};
  wire        opc_last_w  = (bit_cnt_r == `OPC_LAST_BIT);
  wire        addr_last_w = (bit_cnt_r == `ADDR_LAST_BIT);
  wire [7:0]  byte_w      = {hi_r, io_s};

  flash_pe_pkg::op_t dec_op_w;
  assign dec_op_w =
    (opc_w == `OPC_QUAD_PROG)    ? flash_pe_pkg::OP_PROG :
    (opc_w == `OPC_SECT_ERASE)   ? flash_pe_pkg::OP_SE :
    (opc_w == `OPC_BLK32_ERASE)  ? flash_pe_pkg::OP_BE32 :
    (opc_w == `OPC_BLK64_ERASE)  ? flash_pe_pkg::OP_BE64 :
    (opc_w == `OPC_CHIP_ERASE_A) ? flash_pe_pkg::OP_CE :
    (opc_w == `OPC_CHIP_ERASE_B) ? flash_pe_pkg::OP_CE :
                                   flash_pe_pkg::OP_NONE;

  wire is_prog_w = (cmd_r == flash_pe_pkg::OP_PROG);
  wire is_ce_w   = (cmd_r == flash_pe_pkg::OP_CE);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      flash_pe_pkg::F_OPC: begin
        if (opc_last_w) begin
          if (busy_r || dec_op_w == flash_pe_pkg::OP_NONE) begin
            state_nxt = flash_pe_pkg::F_SKIP;
          end else if (dec_op_w == flash_pe_pkg::OP_CE) begin
            state_nxt = flash_pe_pkg::F_END;
          end else if (dec_op_w == flash_pe_pkg::OP_PROG &&
                       !quad_io_allow_bit_i) begin
            state_nxt = flash_pe_pkg::F_SKIP;
          end else begin
            state_nxt = flash_pe_pkg::F_ADDR;
          end
        end
      end
      flash_pe_pkg::F_ADDR: begin
        if (addr_last_w) begin
          state_nxt = is_prog_w ? flash_pe_pkg::F_DATA
                                : flash_pe_pkg::F_END;
        end
      end
      flash_pe_pkg::F_DATA: state_nxt = flash_pe_pkg::F_DATA;
      // A clock past the last bit spoils the boundary
      flash_pe_pkg::F_END:  state_nxt = flash_pe_pkg::F_SKIP;
      flash_pe_pkg::F_SKIP: state_nxt = flash_pe_pkg::F_SKIP;
      default:              state_nxt = flash_pe_pkg::F_SKIP;
    endcase
  end

  wire opc_take_w  = sclk_rise_w & (state_r == flash_pe_pkg::F_OPC) &
                     opc_last_w & ~busy_r &
                     (dec_op_w != flash_pe_pkg::OP_NONE);
  wire addr_take_w = sclk_rise_w & (state_r == flash_pe_pkg::F_ADDR);
  wire byte_done_w = sclk_rise_w & (state_r == flash_pe_pkg::F_DATA) &
                     nib_r;
  wire clear_mask_w = cs_fall_w & ~busy_r;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_d_r   <= 1'b1;
      sclk_d_r <= 1'b0;
    end else begin
      cs_d_r   <= cs_s;
      sclk_d_r <= sclk_s;
    end
  end

  // Any rise of select ends the frame whatever was received
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r   <= flash_pe_pkg::F_OPC;
      bit_cnt_r <= 5'h00;
      sh_r      <= 7'h00;
    end else if (cs_s) begin
      state_r   <= flash_pe_pkg::F_OPC;
      bit_cnt_r <= 5'h00;
    end else if (sclk_rise_w) begin
      state_r   <= state_nxt;
      bit_cnt_r <= (state_nxt != state_r) ? 5'h00 : bit_cnt_r + 5'h01;
      sh_r      <= opc_w[6:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_r      <= flash_pe_pkg::OP_NONE;
      cmd_seen_r <= 1'b0;
      addr_r     <= 24'h000000;
    end else begin
      if (cs_s) begin
        cmd_seen_r <= 1'b0;
      end else if (opc_take_w) begin
        cmd_r      <= dec_op_w;
        cmd_seen_r <= 1'b1;
      end
      if (addr_take_w) begin
        addr_r <= addr_nxt_w;
      end
    end
  end

  // Column wraps inside the page, so later bytes overwrite earlier
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      col_r       <= 8'h00;
      nib_r       <= 1'b0;
      hi_r        <= 4'h0;
      have_byte_r <= 1'b0;
    end else if (cs_s) begin
      nib_r       <= 1'b0;
      have_byte_r <= 1'b0;
    end else if (addr_take_w && addr_last_w) begin
      col_r <= addr_nxt_w[7:0];
    end else if (sclk_rise_w && state_r == flash_pe_pkg::F_DATA) begin
      nib_r <= ~nib_r;
      if (!nib_r) begin
        hi_r <= io_s;
      end else begin
        col_r       <= col_r + 8'h01;
        have_byte_r <= 1'b1;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PAGE_BYTES; gi++) begin : g_page
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          page_r[gi] <= 8'h00;
          mask_r[gi] <= 1'b0;
        end else if (byte_done_w && col_r == 8'(gi)) begin
          page_r[gi] <= byte_w;
          mask_r[gi] <= 1'b1;
        end else if (clear_mask_w) begin
          mask_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  wire bound_ok_w = is_prog_w
    ? (state_r == flash_pe_pkg::F_DATA && !nib_r && have_byte_r)
    : (state_r == flash_pe_pkg::F_END);
  wire ce_ok_w =
    (protect_bits_i[2:0] == 3'h0 && !protect_complement_i) ||
    (protect_bits_i[2:0] == 3'h7 && protect_complement_i);
  wire prot_ok_w = is_ce_w ? ce_ok_w : ~protect_hit_i;
  wire start_w   = cs_rise_w & cmd_seen_r & ~busy_r & bound_ok_w &
                   write_unlock_latch_i & prot_ok_w;

  wire [31:0] limit_w = is_prog_w ? PP_CYCLES :
                        is_ce_w   ? CE_CYCLES : SE_CYCLES;
  wire        cnt_end_w = (busy_cnt_r == limit_w - 32'h00000001);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_r     <= 1'b0;
      busy_cnt_r <= 32'h00000000;
    end else if (start_w) begin
      busy_r     <= 1'b1;
      busy_cnt_r <= 32'h00000000;
    end else if (busy_r) begin
      busy_r     <= ~cnt_end_w;
      busy_cnt_r <= busy_cnt_r + 32'h00000001;
    end
  end

  wire [7:0] idx_w        = busy_cnt_r[7:0];
  wire       prog_phase_w = busy_r & is_prog_w &
                            (busy_cnt_r < `PAGE_BYTES_W);
  wire [23:0] base_w =
    (cmd_r == flash_pe_pkg::OP_SE)   ? (addr_r & `SECT_MASK) :
    (cmd_r == flash_pe_pkg::OP_BE32) ? (addr_r & `BLK32_MASK) :
    (cmd_r == flash_pe_pkg::OP_BE64) ? (addr_r & `BLK64_MASK) :
                                       24'h000000;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      write_unlock_clear_o <= 1'b0;
      array_prog_o         <= 1'b0;
      array_addr_o         <= 24'h000000;
      array_data_o         <= 8'h00;
      array_erase_o        <= 1'b0;
      erase_base_o         <= 24'h000000;
      cmd_discard_o        <= 1'b0;
    end else begin
      write_unlock_clear_o <= start_w;
      array_prog_o         <= prog_phase_w & mask_r[idx_w];
      array_addr_o         <= {addr_r[23:8], idx_w};
      array_data_o         <= page_r[idx_w];
      array_erase_o        <= start_w & ~is_prog_w;
      erase_base_o         <= base_w;
      cmd_discard_o        <= cs_rise_w & cmd_seen_r & ~start_w;
    end
  end

  assign write_in_progress_o = busy_r;
  assign target_addr_o       = addr_r;
  assign target_kind_o       = cmd_r;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  wip_start_a: assert property (
    start_w |=> write_in_progress_o [*8])
    else $error("busy did not follow an accepted command");
  wel_clear_a: assert property (
    $rose(write_in_progress_o) |-> write_unlock_clear_o)
    else $error("write unlock clear missing at cycle start");
  wip_len_a: assert property (
    $fell(write_in_progress_o) |->
      $past(busy_cnt_r) == $past(limit_w) - 32'h00000001)
    else $error("busy length differs from cycle time");
  quad_gate_a: assert property (
    (opc_take_w && dec_op_w == flash_pe_pkg::OP_PROG &&
     !quad_io_allow_bit_i) |=> state_r != flash_pe_pkg::F_ADDR)
    else $error("quad program taken without quad allow");
  prog_bound_a: assert property (
    (start_w && is_prog_w) |-> (!nib_r && have_byte_r))
    else $error("program started off a byte boundary");
  erase_bound_a: assert property (
    (start_w && !is_prog_w) |-> $past(state_r) == flash_pe_pkg::F_END ||
                                state_r == flash_pe_pkg::F_END)
    else $error("erase started off the address boundary");
  protect_a: assert property (
    (start_w && !is_ce_w) |-> !protect_hit_i && write_unlock_latch_i)
    else $error("protected or locked target was started");
  chip_prot_a: assert property (
    (start_w && is_ce_w) |-> (protect_bits_i[2:0] ==
                             {3{protect_complement_i}}))
    else $error("chip erase started under partial protection");
  prog_mask_a: assert property (
    array_prog_o |-> $past(prog_phase_w) && write_in_progress_o)
    else $error("byte written outside the program phase");
  sect_align_a: assert property (
    (array_erase_o && cmd_r == flash_pe_pkg::OP_SE) |->
      erase_base_o[11:0] == 12'h000)
    else $error("sector erase base not aligned");

endmodule

`default_nettype wire

// ===== bench/flash_host_model.sv
// Host side of the serial flash link: drives select, clock and IO.
// Assumes the caller runs on core clock falling edges; 200 ns sclk.
`timescale 1ns/1ps
`default_nettype none

module flash_host_model (
  input  wire logic       core_clk_i,
  output var  logic       spi_cs_b_o,
  output var  logic       spi_sclk_o,
  output var  logic [3:0] spi_io_o
);
  initial begin
    spi_cs_b_o = 1'h1;
    spi_sclk_o = 1'h0;
    spi_io_o   = 4'h0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // Serial clock stands low outside frames
  task automatic tick(input logic [3:0] v);
    spi_io_o = v;
    wait_n(4);
    spi_sclk_o = 1'h1;
    wait_n(4);
    spi_sclk_o = 1'h0;
  endtask

  // Unused lines toggle so a stale level is never mistaken for data
  task automatic frame(input logic [7:0] opc, input logic [23:0] addr,
                       input int nadr, input int nbytes, input int extra,
                       input logic [7:0] d0);
    logic [7:0] d;
    wait_n(1);
    spi_cs_b_o = 1'h0;
    wait_n(4);
    for (int i = 7; i >= 0; i--) tick({~spi_io_o[3:1], opc[i]});
    for (int i = 23; i >= 24 - nadr; i--) begin
      tick({~spi_io_o[3:1], addr[i]});
    end
    for (int k = 0; k < nbytes; k++) begin
      d = (d0 + k[7:0]) ^ {8{k[8]}};
      tick(d[7:4]);
      tick(d[3:0]);
    end
    repeat (extra) tick(~spi_io_o);
    wait_n(4);
    spi_cs_b_o = 1'h1;
    spi_io_o   = ~spi_io_o;
    wait_n(8);
  endtask
endmodule

`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the program and erase sequencer.
// Assumes the host model drives the link; outputs watched per cycle.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int unsigned PP_N = 300;
  localparam int unsigned SE_N = 20;
  localparam int unsigned CE_N = 30;
  // {quad allow, unlock latch, protect window, complement, bits}
  localparam logic [8:0] C_OK  = 9'h180;
  localparam logic [8:0] C_NOQ = 9'h080;
  localparam logic [8:0] C_NOW = 9'h100;
  localparam logic [8:0] C_PRT = 9'h1C0;
  localparam logic [8:0] C_CE7 = 9'h1A7;
  localparam logic [8:0] C_CE1 = 9'h181;

  logic               core_clk = 1'h0;
  logic               rst_b    = 1'h0;
  logic               allow, latch, prot_en, cmp;
  logic [4:0]         pbits;
  logic               cs_b, sclk, prot_hit;
  logic [3:0]         io;
  logic               write_in_progress, clr, prog, ers, disc;
  logic [23:0]        tgt, paddr, ebase, seen_base;
  logic [7:0]         pdata;
  logic [15:0]        seen_page;
  flash_pe_pkg::op_t  kind;
  logic [7:0]         mem [256];
  int                 fail_count = 0;
  int                 tests_run = 0;
  int                 n_busy, n_clr, n_prog, n_ers, n_disc;

  always #12.5 core_clk = ~core_clk;
  assign prot_hit = prot_en && (tgt[23:16] == 8'h70);

  flash_host_model i_host (.core_clk_i(core_clk), .spi_cs_b_o(cs_b),
    .spi_sclk_o(sclk), .spi_io_o(io));

  spi_flash_program_erase #(.PP_CYCLES(PP_N), .SE_CYCLES(SE_N),
    .CE_CYCLES(CE_N)) i_dut (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .spi_cs_b_i(cs_b),
    .spi_sclk_i(sclk), .spi_io_i(io), .quad_io_allow_bit_i(allow),
    .write_unlock_latch_i(latch), .protect_bits_i(pbits),
    .protect_complement_i(cmp), .protect_hit_i(prot_hit),
    .write_in_progress_o(write_in_progress), .write_unlock_clear_o(clr),
    .target_addr_o(tgt), .target_kind_o(kind), .array_prog_o(prog),
    .array_addr_o(paddr), .array_data_o(pdata), .array_erase_o(ers),
    .erase_base_o(ebase), .cmd_discard_o(disc));

  always @(posedge core_clk) begin
    if (write_in_progress) n_busy++;
    if (clr && write_in_progress) n_clr++;
    if (ers) n_ers++;
    if (disc) n_disc++;
    if (ers) seen_base = ebase;
    if (prog) begin
      n_prog++;
      mem[paddr[7:0]] = pdata;
      seen_page = paddr[23:8];
    end
  end

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wait_idle;
    int i;
    repeat (6) @(negedge core_clk);
    for (i = 0; i < 2000 && write_in_progress !== 1'h0; i++) @(negedge core_clk);
    repeat (4) @(negedge core_clk);
    if (write_in_progress !== 1'h0) begin
      fail_count++;
      $display("ERROR busy end expected 0 seen %0h", write_in_progress);
      results();
    end
  endtask

  // One frame; busy of zero means the command must be discarded
  task automatic run(input logic [7:0] opc, input logic [23:0] addr,
    input int nadr, input int nb, input int extra, input logic [8:0] cfg,
    input int busy, input logic [23:0] base);
    logic go, pr;
    flash_pe_pkg::op_t ek;
    go = (busy != 0);
    pr = go && (opc == 8'h32);
    ek = (opc == 8'h32) ? flash_pe_pkg::OP_PROG :
         (opc == 8'h20) ? flash_pe_pkg::OP_SE :
         (opc == 8'h52) ? flash_pe_pkg::OP_BE32 :
         (opc == 8'hD8) ? flash_pe_pkg::OP_BE64 : flash_pe_pkg::OP_CE;
    @(negedge core_clk);
    {allow, latch, prot_en, cmp, pbits} = cfg;
    {n_busy, n_clr, n_prog, n_ers, n_disc} = '0;
    i_host.frame(opc, addr, nadr, nb, extra, 8'h5A);
    wait_idle();
    chk("busy cycles", busy, n_busy);
    chk("unlock clears", go, n_clr);
    chk("discards", !go, n_disc);
    chk("erase starts", go && !pr, n_ers);
    chk("bytes programmed", pr ? ((nb > 256) ? 256 : nb) : 0, n_prog);
    chk("command kind", ek, kind);
    if (go && !pr) chk("erase base", base, seen_base);
    if (pr) chk("page", addr[23:8], seen_page);
  endtask

  initial begin
    {allow, latch, prot_en, cmp, pbits} = C_OK;
    repeat (20) @(negedge core_clk);
    rst_b = 1'h1;
    repeat (5) @(negedge core_clk);
    run(8'h32, 24'h1234FE, 24, 3, 0, C_OK, PP_N, 0);
    chk("col FE", 8'h5A, mem[8'hFE]);
    chk("col 00", 8'h5C, mem[8'h00]);
    run(8'h32, 24'h123400, 24, 258, 0, C_OK, PP_N, 0);
    chk("col 00", 8'hA5, mem[8'h00]);
    chk("col 01", 8'hA4, mem[8'h01]);
    chk("col 02", 8'h5C, mem[8'h02]);
    run(8'h32, 24'h123400, 24, 2, 0, C_NOQ, 0, 0);
    run(8'h32, 24'h123400, 24, 2, 1, C_OK, 0, 0);
    run(8'h32, 24'h123400, 24, 0, 0, C_OK, 0, 0);
    run(8'h32, 24'h123400, 24, 2, 0, C_NOW, 0, 0);
    run(8'h32, 24'h7012FE, 24, 2, 0, C_PRT, 0, 0);
    run(8'h20, 24'h345678, 24, 0, 0, C_OK, SE_N, 24'h345000);
    run(8'h52, 24'h34ABCD, 24, 0, 0, C_OK, SE_N, 24'h348000);
    run(8'hD8, 24'h34ABCD, 24, 0, 0, C_OK, SE_N, 24'h340000);
    run(8'h20, 24'h345678, 24, 0, 1, C_OK, 0, 0);
    run(8'h52, 24'h34ABCD, 24, 0, 1, C_OK, 0, 0);
    run(8'h20, 24'h701234, 24, 0, 0, C_PRT, 0, 0);
    run(8'h52, 24'h701234, 24, 0, 0, C_PRT, 0, 0);
    run(8'hD8, 24'h701234, 24, 0, 0, C_PRT, 0, 0);
    run(8'h60, 24'h000000, 0, 0, 0, C_OK, CE_N, 0);
    run(8'hC7, 24'h000000, 0, 0, 0, C_CE7, CE_N, 0);
    run(8'h60, 24'h000000, 0, 0, 0, C_CE1, 0, 0);
    run(8'hC7, 24'h000000, 0, 0, 1, C_OK, 0, 0);
    results();
  end
endmodule

`default_nettype wire
